// ### shared/pdm_pkg.sv
// constants for the power-down clock control block
package pdm_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [3:0] OFS_STANDBY_SELECT_CTL   = 4'h0;
  localparam logic [3:0] OFS_STANDBY_SELECT_CTL2  = 4'h4;
  localparam logic [3:0] OFS_CLK_STOP   = 4'h8;
  localparam logic [3:0] OFS_CLK_RESUME = 4'hC;
  // ==========================================================
  // standby_control fields
  localparam int B_STANDBY_SEL  = 7;
  localparam int B_PIN_FLOAT    = 6;
  localparam int B_PULLUP_DIS   = 5;
  localparam int B_DMA_STOP     = 4;
  localparam int B_FIFO_SER_STOP = 3;
  localparam int B_TIMER_STOP   = 2;
  localparam int B_CLK_UNIT_STOP = 1;
  localparam int B_SERIAL_STOP  = 0;
  localparam logic [7:0] RST_STANDBY_SELECT_CTL = 8'h00;
  // ==========================================================
  // standby_control_two fields
  localparam int B_DEEP_SLEEP   = 7;
  localparam int B_STATUS_DRIVE = 6;
  localparam int B_SQ_STOP      = 1;
  localparam int B_BREAK_STOP   = 0;
  localparam logic [7:0] RST_STANDBY_SELECT_CTL2 = 8'h00;
  localparam logic [7:0] MSK_STANDBY_SELECT_CTL2 = 8'hC3;
  // ==========================================================
  // peripheral_clock_stop fields
  localparam int B_TMR_HI_STOP  = 1;
  localparam int B_INTERRUPT_CONTROLLER_STOP    = 0;
  localparam int CLK_STOP_W     = 2;
  localparam logic [CLK_STOP_W-1:0] RST_CLK_STOP = 2'h0;
  // ==========================================================
  // gated clock indices
  localparam int G_DMA = 0;
  localparam int G_FIFO_SER = 1;
  localparam int G_TIMER = 2;
  localparam int G_RTC_IF = 3;
  localparam int G_SERIAL = 4;
  localparam int G_SQ = 5;
  localparam int G_BREAK = 6;
  localparam int G_TMR_HI = 7;
  localparam int G_INTERRUPT_CONTROLLER = 8;
  localparam int N_GATES = 9;
  // ==========================================================
  // pin groups and status codes {high, low}
  localparam int N_FLOAT_PINS = 9;
  localparam int N_PULL_PINS = 16;
  localparam logic [1:0] STATUS_HW_STANDBY_SELECT = 2'h1;
endpackage : pdm_pkg

// ### core/pdm_top.sv
// power-down control: standby registers, module clock gates, pin control
`timescale 1ns/1ps

// ==========================================================
// glitch-free clock gate
module pdm_clk_gate (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic en,
  // gated clock
  output wire logic gclk
);
  logic en_q;

  // enable changes only while clk is low
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b1;
    end else begin
      en_q <= en; // RQ25
    end
  end

  assign gclk = clk & en_q; // RQ25
endmodule : pdm_clk_gate

// ==========================================================
// top
// What this block does
// RQ1 - dma_stop set stops DMA controller clock
// RQ2 - software ends DMA, then reprograms it
// RQ3 - fifo_serial_stop stops second serial port clock
// RQ4 - timer_stop stops timer unit clock
// RQ5 - clock_unit_stop cuts realtime clock interface clock
// RQ6 - serial_stop stops first serial port clock
// RQ7 - pin_float_in_standby floats pins in standby
// RQ8 - float ignored on pins used as outputs
// RQ9 - pullups on unless pullup_disable is set
// RQ10 - pullup_disable ignored in hardware standby
// RQ11 - power-on reset clears standby_control_two
// RQ12 - deep_sleep_select picks deep sleep if not standby
// RQ13 - hardware standby: status pins float or LH
// RQ14 - reserved control-two bits read zero
// RQ15 - store_queue_stop stops store queue clock
// RQ16 - break_unit_stop stops break controller clock
// RQ17 - clock-stop bits set by one, zero ignored
// RQ18 - software resumes clocks via resume register
// RQ19 - clock-stop register cleared only at power-on
// RQ20 - clock-stop bits 31..2 read zero
// RQ21 - timer high channels stop clock
// RQ22 - interrupt clock stop blocks high timer interrupts
// RQ23 - standby_select picks standby over sleep
// RQ24 - resume register clears bits written one
// RQ25 - clock gates switch without glitches
module pdm_top (
  // clock and power-on reset
  input  wire logic                              CLK_SYS,
  input  wire logic                              RESETN,
  // avalon-mm slave
  input  wire logic [3:0]                        AVS_ADDRESS,
  input  wire logic                              AVS_READ,
  input  wire logic                              AVS_WRITE,
  input  wire logic [31:0]                       AVS_WRITEDATA,
  input  wire logic [3:0]                        AVS_BYTEENABLE,
  output logic      [31:0]                       AVS_READDATA,
  output wire logic                              AVS_WAITREQUEST,
  // sleep instruction and mode requests
  input  wire logic                              SLEEP_REQ,
  output logic                                   ENTER_SLEEP,
  output logic                                   ENTER_DEEP_SLEEP,
  output logic                                   ENTER_STANDBY,
  // mode state
  input  wire logic                              STANDBY_ACTIVE,
  input  wire logic                              HW_STANDBY_N,
  // peripheral pin control
  input  wire logic [pdm_pkg::N_FLOAT_PINS-1:0]  PORT_OUT_SEL,
  input  wire logic [pdm_pkg::N_PULL_PINS-1:0]   PIN_IN_OR_HIZ,
  output logic      [pdm_pkg::N_FLOAT_PINS-1:0]  PIN_FLOAT,
  output logic      [pdm_pkg::N_PULL_PINS-1:0]   PULLUP_EN,
  // status pins {high, low}
  input  wire logic [1:0]                        STATUS_CODE,
  output logic      [1:0]                        STATUS_OUT,
  output logic      [1:0]                        STATUS_OE,
  // gated module clocks
  output wire logic                              CLK_DMA,
  output wire logic                              CLK_FIFO_SERIAL,
  output wire logic                              CLK_TIMER,
  output wire logic                              CLK_RTC_IF,
  output wire logic                              CLK_SERIAL,
  output wire logic                              CLK_STORE_QUEUE,
  output wire logic                              CLK_BREAK,
  output wire logic                              CLK_TIMER_HI,
  output wire logic                              CLK_INTERRUPT_CONTROLLER
);
  // ==========================================================
  // state
  logic [7:0]                          standby_select_ctl;
  logic [7:0]                          standby_select_ctl2;
  logic [pdm_pkg::CLK_STOP_W-1:0]      clk_stop;
  logic                                ack;
  logic                                hw_sync1;
  logic                                hw_sync2;

  // ==========================================================
  // bus decode
  wire       req        = AVS_READ | AVS_WRITE;
  wire       take       = req & ack;
  wire       wr_take    = AVS_WRITE & ack & AVS_BYTEENABLE[0];
  wire       sel_ctl    = (AVS_ADDRESS == pdm_pkg::OFS_STANDBY_SELECT_CTL);
  wire       sel_ctl2   = (AVS_ADDRESS == pdm_pkg::OFS_STANDBY_SELECT_CTL2);
  wire       sel_stop   = (AVS_ADDRESS == pdm_pkg::OFS_CLK_STOP);
  wire       sel_resume = (AVS_ADDRESS == pdm_pkg::OFS_CLK_RESUME);
  wire [pdm_pkg::CLK_STOP_W-1:0] wd_stop = AVS_WRITEDATA[pdm_pkg::CLK_STOP_W-1:0];

  assign AVS_WAITREQUEST = req & ~ack;

  // read mux, reserved bits as zero
  wire [31:0] rd_mux;
  assign rd_mux = sel_ctl  ? {24'h000000, standby_select_ctl} :
                  sel_ctl2 ? {24'h000000, standby_select_ctl2 & pdm_pkg::MSK_STANDBY_SELECT_CTL2} : // RQ14
                  sel_stop ? {30'h00000000, clk_stop} : // RQ20
                  32'h00000000;

  // ==========================================================
  // next values
  wire [7:0] next_standby_select_ctl  = (wr_take && sel_ctl) ? AVS_WRITEDATA[7:0] : standby_select_ctl;
  wire [7:0] next_standby_select_ctl2 = (wr_take && sel_ctl2)
                              ? (AVS_WRITEDATA[7:0] & pdm_pkg::MSK_STANDBY_SELECT_CTL2) // RQ14
                              : standby_select_ctl2;
  wire [pdm_pkg::CLK_STOP_W-1:0] next_clk_stop =
    (wr_take && sel_stop)   ? (clk_stop | wd_stop) :  // RQ17
    (wr_take && sel_resume) ? (clk_stop & ~wd_stop) : // RQ24
    clk_stop;

  // ==========================================================
  // registers, cleared only by power-on reset
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      standby_select_ctl  <= pdm_pkg::RST_STANDBY_SELECT_CTL;
      standby_select_ctl2 <= pdm_pkg::RST_STANDBY_SELECT_CTL2; // RQ11
      clk_stop  <= pdm_pkg::RST_CLK_STOP;  // RQ19
    end else begin
      standby_select_ctl  <= next_standby_select_ctl;
      standby_select_ctl2 <= next_standby_select_ctl2;
      clk_stop  <= next_clk_stop;
    end
  end

  // one wait cycle, read data loaded with the ack
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ack          <= 1'b0;
      AVS_READDATA <= 32'h00000000;
    end else begin
      ack          <= req & ~ack;
      AVS_READDATA <= (AVS_READ & ~ack) ? rd_mux : AVS_READDATA;
    end
  end

  // ==========================================================
  // hardware standby pin synchroniser
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      hw_sync1 <= 1'b1;
      hw_sync2 <= 1'b1;
    end else begin
      hw_sync1 <= HW_STANDBY_N;
      hw_sync2 <= hw_sync1;
    end
  end

  wire hw_standby_select = ~hw_sync2;

  // ==========================================================
  // sleep instruction mode select
  wire standby_select_sel = standby_select_ctl[pdm_pkg::B_STANDBY_SEL];
  wire deep_sleep_select_sel = standby_select_ctl2[pdm_pkg::B_DEEP_SLEEP];
  wire go_standby_select  = SLEEP_REQ & standby_select_sel;              // RQ23
  wire go_deep  = SLEEP_REQ & ~standby_select_sel & deep_sleep_select_sel;  // RQ12
  wire go_sleep = SLEEP_REQ & ~standby_select_sel & ~deep_sleep_select_sel; // RQ23

  // ==========================================================
  // pin control
  wire [pdm_pkg::N_FLOAT_PINS-1:0] next_float =
    {pdm_pkg::N_FLOAT_PINS{standby_select_ctl[pdm_pkg::B_PIN_FLOAT] & STANDBY_ACTIVE}}
    & ~PORT_OUT_SEL; // RQ7 RQ8
  wire pull_on = ~standby_select_ctl[pdm_pkg::B_PULLUP_DIS] & ~hw_standby_select; // RQ9 RQ10
  wire [pdm_pkg::N_PULL_PINS-1:0] next_pull =
    {pdm_pkg::N_PULL_PINS{pull_on}} & PIN_IN_OR_HIZ; // RQ9
  wire status_pin_drive = standby_select_ctl2[pdm_pkg::B_STATUS_DRIVE];
  wire [1:0] next_st_oe  = (hw_standby_select && !status_pin_drive) ? 2'h0 : 2'h3; // RQ13
  wire [1:0] next_st_out = hw_standby_select ? pdm_pkg::STATUS_HW_STANDBY_SELECT : STATUS_CODE; // RQ13

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ENTER_SLEEP      <= 1'b0;
      ENTER_DEEP_SLEEP <= 1'b0;
      ENTER_STANDBY    <= 1'b0;
      PIN_FLOAT        <= '0;
      PULLUP_EN        <= '0;
      STATUS_OUT       <= 2'h0;
      STATUS_OE        <= 2'h0;
    end else begin
      ENTER_SLEEP      <= go_sleep;
      ENTER_DEEP_SLEEP <= go_deep;
      ENTER_STANDBY    <= go_standby_select;
      PIN_FLOAT        <= next_float;
      PULLUP_EN        <= next_pull;
      STATUS_OUT       <= next_st_out;
      STATUS_OE        <= next_st_oe;
    end
  end

  // ==========================================================
  // module clock gates
  wire [pdm_pkg::N_GATES-1:0] run_en;
  wire [pdm_pkg::N_GATES-1:0] gclk;

  assign run_en[pdm_pkg::G_DMA]      = ~standby_select_ctl[pdm_pkg::B_DMA_STOP];      // RQ1
  assign run_en[pdm_pkg::G_FIFO_SER] = ~standby_select_ctl[pdm_pkg::B_FIFO_SER_STOP]; // RQ3
  assign run_en[pdm_pkg::G_TIMER]    = ~standby_select_ctl[pdm_pkg::B_TIMER_STOP];    // RQ4
  assign run_en[pdm_pkg::G_RTC_IF]   = ~standby_select_ctl[pdm_pkg::B_CLK_UNIT_STOP]; // RQ5
  assign run_en[pdm_pkg::G_SERIAL]   = ~standby_select_ctl[pdm_pkg::B_SERIAL_STOP];   // RQ6
  assign run_en[pdm_pkg::G_SQ]       = ~standby_select_ctl2[pdm_pkg::B_SQ_STOP];      // RQ15
  assign run_en[pdm_pkg::G_BREAK]    = ~standby_select_ctl2[pdm_pkg::B_BREAK_STOP];   // RQ16
  assign run_en[pdm_pkg::G_TMR_HI]   = ~clk_stop[pdm_pkg::B_TMR_HI_STOP];   // RQ21
  assign run_en[pdm_pkg::G_INTERRUPT_CONTROLLER]     = ~clk_stop[pdm_pkg::B_INTERRUPT_CONTROLLER_STOP];     // RQ22

  genvar gi;
  generate
    for (gi = 0; gi < pdm_pkg::N_GATES; gi = gi + 1) begin : g_gate
      pdm_clk_gate u_gate (
        .clk   (CLK_SYS),
        .rst_n (RESETN),
        .en    (run_en[gi]),
        .gclk  (gclk[gi])
      );
    end
  endgenerate

  // rtc counters run on their own clock; only the interface clock stops
  assign CLK_DMA         = gclk[pdm_pkg::G_DMA];
  assign CLK_FIFO_SERIAL = gclk[pdm_pkg::G_FIFO_SER];
  assign CLK_TIMER       = gclk[pdm_pkg::G_TIMER];
  assign CLK_RTC_IF      = gclk[pdm_pkg::G_RTC_IF];
  assign CLK_SERIAL      = gclk[pdm_pkg::G_SERIAL];
  assign CLK_STORE_QUEUE = gclk[pdm_pkg::G_SQ];
  assign CLK_BREAK       = gclk[pdm_pkg::G_BREAK];
  assign CLK_TIMER_HI    = gclk[pdm_pkg::G_TMR_HI];
  assign CLK_INTERRUPT_CONTROLLER        = gclk[pdm_pkg::G_INTERRUPT_CONTROLLER];

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  sequence s_req_open;
    req && !ack;
  endsequence

  sequence s_req_taken;
    ##1 (!AVS_WAITREQUEST && ack);
  endsequence

  a_bus_one_wait: assert property (s_req_open |-> s_req_taken)
    else $error("request not answered after one wait cycle");

  a_stop_w1s_keep: assert property ( // RQ17
    (wr_take && sel_stop && wd_stop == 2'h0) |=> $stable(clk_stop))
    else $error("zero write changed clock-stop register");

  a_stop_w1s_set: assert property ( // RQ17
    (wr_take && sel_stop && wd_stop[pdm_pkg::B_INTERRUPT_CONTROLLER_STOP]) |=> clk_stop[pdm_pkg::B_INTERRUPT_CONTROLLER_STOP])
    else $error("one write did not set stop bit");

  a_resume_clear: assert property ( // RQ24
    (wr_take && sel_resume && wd_stop[pdm_pkg::B_TMR_HI_STOP])
    |=> !clk_stop[pdm_pkg::B_TMR_HI_STOP] && !run_en[pdm_pkg::G_TMR_HI] == 1'b0)
    else $error("resume write did not clear stop bit");

  a_ctl2_reserved: assert property ( // RQ14
    (AVS_READ && !ack && sel_ctl2) |=> (AVS_READDATA[5:2] == 4'h0))
    else $error("reserved control-two bits read non-zero");

  a_stop_upper_zero: assert property ( // RQ20
    (AVS_READ && !ack && sel_stop) |=> (AVS_READDATA[31:2] == 30'h00000000))
    else $error("clock-stop upper bits read non-zero");

  a_dma_gate_off: assert property ( // RQ1
    (wr_take && sel_ctl && AVS_WRITEDATA[pdm_pkg::B_DMA_STOP]) |=> !run_en[pdm_pkg::G_DMA])
    else $error("dma clock enable stayed on");

  a_deep_sleep_sel: assert property ( // RQ12
    (SLEEP_REQ && deep_sleep_select_sel && !standby_select_sel) |=> (ENTER_DEEP_SLEEP && !ENTER_SLEEP))
    else $error("deep sleep not selected");

  a_standby_sel: assert property ( // RQ23
    (SLEEP_REQ && standby_select_sel) |=> (ENTER_STANDBY && !ENTER_DEEP_SLEEP && !ENTER_SLEEP))
    else $error("standby not selected");

  a_float_port_out: assert property ( // RQ8
    ##1 ((PIN_FLOAT & $past(PORT_OUT_SEL)) == '0))
    else $error("output port pin was floated");

  a_pullup_hwstby: assert property ( // RQ10
    hw_standby_select |=> (PULLUP_EN == '0))
    else $error("pullups enabled in hardware standby");

  a_status_lh: assert property ( // RQ13
    (hw_standby_select && status_pin_drive) |=> (STATUS_OE == 2'h3 && STATUS_OUT == pdm_pkg::STATUS_HW_STANDBY_SELECT))
    else $error("status pins not driven low-high");

  a_status_float: assert property ( // RQ13
    (hw_standby_select && !status_pin_drive) |=> (STATUS_OE == 2'h0))
    else $error("status pins not floated");

  a_fifo_gate_off: assert property ( // RQ3
    (wr_take && sel_ctl && AVS_WRITEDATA[pdm_pkg::B_FIFO_SER_STOP])
    |=> !run_en[pdm_pkg::G_FIFO_SER])
    else $error("second serial clock enable stayed on");

  a_timer_gate_off: assert property ( // RQ4
    (wr_take && sel_ctl && AVS_WRITEDATA[pdm_pkg::B_TIMER_STOP])
    |=> !run_en[pdm_pkg::G_TIMER])
    else $error("timer clock enable stayed on");

  a_rtc_gate_off: assert property ( // RQ5
    (wr_take && sel_ctl && AVS_WRITEDATA[pdm_pkg::B_CLK_UNIT_STOP])
    |=> !run_en[pdm_pkg::G_RTC_IF])
    else $error("rtc interface clock enable stayed on");

  a_serial_gate_off: assert property ( // RQ6
    (wr_take && sel_ctl && AVS_WRITEDATA[pdm_pkg::B_SERIAL_STOP])
    |=> !run_en[pdm_pkg::G_SERIAL])
    else $error("first serial clock enable stayed on");

  a_sq_gate_off: assert property ( // RQ15
    (wr_take && sel_ctl2 && AVS_WRITEDATA[pdm_pkg::B_SQ_STOP])
    |=> !run_en[pdm_pkg::G_SQ])
    else $error("store queue clock enable stayed on");

  a_break_gate_off: assert property ( // RQ16
    (wr_take && sel_ctl2 && AVS_WRITEDATA[pdm_pkg::B_BREAK_STOP])
    |=> !run_en[pdm_pkg::G_BREAK])
    else $error("break clock enable stayed on");

  a_tmr_hi_gate_off: assert property ( // RQ21
    (wr_take && sel_stop && wd_stop[pdm_pkg::B_TMR_HI_STOP])
    |=> !run_en[pdm_pkg::G_TMR_HI])
    else $error("timer high channel clock enable stayed on");

  a_interrupt_controller_gate_off: assert property ( // RQ22
    (wr_take && sel_stop && wd_stop[pdm_pkg::B_INTERRUPT_CONTROLLER_STOP])
    |=> !run_en[pdm_pkg::G_INTERRUPT_CONTROLLER])
    else $error("interrupt clock enable stayed on");

  a_dma_gate_on: assert property ( // RQ1
    (wr_take && sel_ctl && !AVS_WRITEDATA[pdm_pkg::B_DMA_STOP])
    |=> run_en[pdm_pkg::G_DMA])
    else $error("dma clock enable stayed off");

  a_float_standby: assert property ( // RQ7
    (standby_select_ctl[pdm_pkg::B_PIN_FLOAT] && STANDBY_ACTIVE) |=> (PIN_FLOAT == ~$past(PORT_OUT_SEL)))
    else $error("pins not floated in standby");

  a_float_off: assert property ( // RQ7
    !STANDBY_ACTIVE |=> (PIN_FLOAT == '0))
    else $error("pins floated outside standby");

  a_pullup_on: assert property ( // RQ9
    (!standby_select_ctl[pdm_pkg::B_PULLUP_DIS] && !hw_standby_select) |=> (PULLUP_EN == $past(PIN_IN_OR_HIZ)))
    else $error("pullups not following pin state");

  a_pullup_off: assert property ( // RQ9
    standby_select_ctl[pdm_pkg::B_PULLUP_DIS] |=> (PULLUP_EN == '0))
    else $error("pullups on while disabled");

  a_sleep_sel: assert property ( // RQ23
    (SLEEP_REQ && !standby_select_sel && !deep_sleep_select_sel) |=> (ENTER_SLEEP && !ENTER_DEEP_SLEEP && !ENTER_STANDBY))
    else $error("sleep not selected");

  a_resume_keep: assert property ( // RQ24
    (wr_take && sel_resume && wd_stop == 2'h0) |=> $stable(clk_stop))
    else $error("zero resume write changed clock-stop register");

  a_lane_refused: assert property (
    (AVS_WRITE && ack && !AVS_BYTEENABLE[0]) |=> ($stable(standby_select_ctl) && $stable(clk_stop)))
    else $error("write without lane zero changed a register");
endmodule : pdm_top

// ### verification/tb_power_down_module_clock_gating.sv
// self-checking bench for the power-down clock control block
`timescale 1ns/1ps
module tb_power_down_module_clock_gating;
  // ==========================================================
  // signals
  logic        CLK_SYS, RESETN, AVS_READ, AVS_WRITE, SLEEP_REQ, STANDBY_ACTIVE, HW_STANDBY_N;
  logic [3:0]  AVS_ADDRESS, AVS_BYTEENABLE;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  logic        AVS_WAITREQUEST, ENTER_SLEEP, ENTER_DEEP_SLEEP, ENTER_STANDBY;
  logic [8:0]  PORT_OUT_SEL, PIN_FLOAT;
  logic [15:0] PIN_IN_OR_HIZ, PULLUP_EN;
  logic [1:0]  STATUS_CODE, STATUS_OUT, STATUS_OE;
  logic        CLK_DMA, CLK_FIFO_SERIAL, CLK_TIMER, CLK_RTC_IF, CLK_SERIAL;
  logic        CLK_STORE_QUEUE, CLK_BREAK, CLK_TIMER_HI, CLK_INTERRUPT_CONTROLLER;
  wire  [8:0]  gclk = {CLK_INTERRUPT_CONTROLLER, CLK_TIMER_HI, CLK_BREAK, CLK_STORE_QUEUE, CLK_SERIAL,
                       CLK_RTC_IF, CLK_TIMER, CLK_FIFO_SERIAL, CLK_DMA};
  int          n_fail = 0;
  int          comparisons = 0;
  // ==========================================================
  // design
  pdm_top dut_u (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .SLEEP_REQ(SLEEP_REQ), .ENTER_SLEEP(ENTER_SLEEP),
    .ENTER_DEEP_SLEEP(ENTER_DEEP_SLEEP), .ENTER_STANDBY(ENTER_STANDBY),
    .STANDBY_ACTIVE(STANDBY_ACTIVE), .HW_STANDBY_N(HW_STANDBY_N), .PORT_OUT_SEL(PORT_OUT_SEL),
    .PIN_IN_OR_HIZ(PIN_IN_OR_HIZ), .PIN_FLOAT(PIN_FLOAT), .PULLUP_EN(PULLUP_EN),
    .STATUS_CODE(STATUS_CODE), .STATUS_OUT(STATUS_OUT), .STATUS_OE(STATUS_OE),
    .CLK_DMA(CLK_DMA), .CLK_FIFO_SERIAL(CLK_FIFO_SERIAL), .CLK_TIMER(CLK_TIMER),
    .CLK_RTC_IF(CLK_RTC_IF), .CLK_SERIAL(CLK_SERIAL), .CLK_STORE_QUEUE(CLK_STORE_QUEUE),
    .CLK_BREAK(CLK_BREAK), .CLK_TIMER_HI(CLK_TIMER_HI), .CLK_INTERRUPT_CONTROLLER(CLK_INTERRUPT_CONTROLLER));
  // ==========================================================
  // clock
  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  // ==========================================================
  // helpers
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge CLK_SYS);
    AVS_ADDRESS   <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE     <= wr;
    AVS_READ      <= !wr;
    for (n = 0; n < 20; n++) begin
      @(posedge CLK_SYS);
      if (AVS_WAITREQUEST === 1'b0) break;
    end
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ  <= 1'b0;
    if (n == 20) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, 32'h1, 32'h0);
      report_and_stop();
    end
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd

  task automatic clocks(input logic [8:0] stop);
    repeat (3) @(posedge CLK_SYS);
    #2;
    chk({23'h0, gclk}, {23'h0, ~stop});
  endtask : clocks

  task automatic sleep_is(input logic [2:0] exp);
    @(posedge CLK_SYS);
    SLEEP_REQ <= 1'b1;
    @(posedge CLK_SYS);
    SLEEP_REQ <= 1'b0;
    #1;
    chk({29'h0, ENTER_SLEEP, ENTER_DEEP_SLEEP, ENTER_STANDBY}, {29'h0, exp});
  endtask : sleep_is
  // ==========================================================
  // scenarios
  task automatic t_reset_values;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    rd(4'h8, 32'h0);
    rd(4'hC, 32'h0);
    rd(4'h2, 32'h0);
    clocks(9'h000);
    $display("reset values done");
  endtask : t_reset_values

  task automatic t_module_stops;
    wr(4'h0, 32'h11);
    rd(4'h0, 32'h11);
    clocks(9'h011);
    wr(4'h0, 32'h0E);
    clocks(9'h00E);
    wr(4'h0, 32'h0);
    clocks(9'h000);
    wr(4'h4, 32'hC3);
    rd(4'h4, 32'hC3);
    clocks(9'h060);
    wr(4'h4, 32'h02);
    clocks(9'h020);
    wr(4'h4, 32'h0);
    AVS_BYTEENABLE <= 4'hE;
    wr(4'h0, 32'h1F);
    AVS_BYTEENABLE <= 4'hF;
    rd(4'h0, 32'h0);
    $display("module stops done");
  endtask : t_module_stops

  task automatic t_clock_stop;
    wr(4'h8, 32'h1);
    wr(4'h8, 32'h0);
    rd(4'h8, 32'h1);
    clocks(9'h100);
    wr(4'h8, 32'h3);
    rd(4'h8, 32'h3);
    clocks(9'h180);
    wr(4'hC, 32'h1);
    rd(4'h8, 32'h2);
    wr(4'h0, 32'h1F);
    wr(4'h0, 32'h0);
    rd(4'h8, 32'h2);
    wr(4'hC, 32'h2);
    clocks(9'h000);
    $display("clock stop done");
  endtask : t_clock_stop

  task automatic t_sleep_modes;
    sleep_is(3'b100);
    wr(4'h4, 32'h80);
    sleep_is(3'b010);
    wr(4'h0, 32'h80);
    sleep_is(3'b001);
    wr(4'h0, 32'h0);
    wr(4'h4, 32'h0);
    $display("sleep modes done");
  endtask : t_sleep_modes

  task automatic t_pins;
    wr(4'h0, 32'h40);
    @(posedge CLK_SYS);
    STANDBY_ACTIVE <= 1'b1;
    PORT_OUT_SEL   <= 9'h0F0;
    repeat (2) @(posedge CLK_SYS);
    #1;
    chk({23'h0, PIN_FLOAT}, 32'h10F);
    chk({16'h0, PULLUP_EN}, 32'hA5A5);
    chk({28'h0, STATUS_OE, STATUS_OUT}, 32'hE);
    wr(4'h0, 32'h20);
    @(posedge CLK_SYS);
    #1;
    chk({16'h0, PULLUP_EN}, 32'h0);
    chk({23'h0, PIN_FLOAT}, 32'h0);
    wr(4'h0, 32'h0);
    @(posedge CLK_SYS);
    HW_STANDBY_N <= 1'b0;
    repeat (5) @(posedge CLK_SYS);
    #1;
    chk({16'h0, PULLUP_EN}, 32'h0);
    chk({30'h0, STATUS_OE}, 32'h0);
    wr(4'h4, 32'h40);
    repeat (2) @(posedge CLK_SYS);
    #1;
    chk({28'h0, STATUS_OE, STATUS_OUT}, 32'hD);
    $display("pins done");
  endtask : t_pins

  task automatic t_power_on_reset;
    wr(4'h8, 32'h3);
    @(posedge CLK_SYS);
    RESETN       <= 1'b0;
    HW_STANDBY_N <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    rd(4'h8, 32'h0);
    rd(4'h4, 32'h0);
    $display("power-on reset done");
  endtask : t_power_on_reset
  // ==========================================================
  // main sequence
  initial begin
    RESETN = 1'b0;
    AVS_ADDRESS = 4'h0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h0;
    AVS_BYTEENABLE = 4'hF;
    SLEEP_REQ = 1'b0;
    STANDBY_ACTIVE = 1'b0;
    HW_STANDBY_N = 1'b1;
    PORT_OUT_SEL = 9'h0;
    PIN_IN_OR_HIZ = 16'hA5A5;
    STATUS_CODE = 2'h2;
    repeat (8) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    t_reset_values();
    t_module_stops();
    t_clock_stop();
    t_sleep_modes();
    t_pins();
    t_power_on_reset();
    report_and_stop();
  end
endmodule : tb_power_down_module_clock_gating
